// ---- rtl/pei_map.vh ----
// pei_map.vh: register indices, field positions, reset values and
// line state codes of the physical-layer event interrupt block.
// assumes plain Verilog-2005; included by bare name.
`ifndef PEI_MAP_VH
`define PEI_MAP_VH

// ==================================================================
// register indices (byte address is four times the index)
`define PEI_IDX_MASK      5'h02
`define PEI_IDX_THRESHOLD 5'h05
`define PEI_IDX_EVENT     5'h17
`define PEI_IDX_CONTROL   5'h1F

// ==================================================================
// reset values
`define PEI_RST_MASK      16'h0000
`define PEI_RST_THRESHOLD 8'h00
`define PEI_RST_EVENT     16'h0000
`define PEI_RST_CONTROL   6'h00

// ==================================================================
// event bit positions
`define PEI_EV_ACCESS_FAULT 15
`define PEI_EV_SIG_DETECT   14
`define PEI_EV_LINK_ERROR   13
`define PEI_EV_IDLE_GAP     12
`define PEI_EV_VIOLATION    11
`define PEI_EV_PHY_INVALID  10
`define PEI_EV_EBUF_FAULT   9
`define PEI_EV_NOISE_ZERO   8
`define PEI_EV_CONNECT_ZERO 7
`define PEI_EV_ENABLED      6
`define PEI_EV_BREAK        5
`define PEI_EV_TRACE_QH     4
`define PEI_EV_TRACE_FWD    3
`define PEI_EV_CODE         2
`define PEI_EV_LS_HIT       1
`define PEI_EV_PARITY       0

// ==================================================================
// own control register fields
`define PEI_CTL_SELF_TEST   0
`define PEI_CTL_IDLE_SEL    1
`define PEI_CTL_VIOL_SEL    2
`define PEI_CTL_LS_LSB      3
`define PEI_CTL_LS_MSB      5

// ==================================================================
// line state codes (plain defaults)
`define PEI_LS_QUIET  3'h0
`define PEI_LS_HALT   3'h2
`define PEI_LS_MASTER 3'h3

// ==================================================================
// bus responses
`define PEI_RESP_OKAY   2'h0
`define PEI_RESP_SLVERR 2'h2
`define PEI_RESP_DECERR 2'h3

`endif

// ---- rtl/pei_event_irq.v ----
// pei_event_irq.v: physical-layer event register, mask, threshold
// and active-low interrupt, reached over an AXI4-Lite slave.
// assumes all event inputs are synchronous to clock; pulses last
// one cycle, levels are edge detected here.
//
// Our own choice: the AXI4-Lite interface to the registers.
`include "pei_map.vh"
`default_nettype none

// Behaviour
// - threshold register at index 05, read/write, cleared by reset
// - threshold low byte is the compare value for link-error event
// - threshold bits 15..8 ignore writes and read zero
// - event register at index 17 read-only, cleared on read and reset
// - each event bit pairs with the same mask bit for the interrupt
// - self-test run blocks all but completion; run cleared ends it
// - bit 15 on invalid host access of any listed kind
// - bit 14 on rising signal detect input
// - bit 13 when link error counter becomes equal to threshold
// - bit 12 on idle minimum drop, or gap count increment/overflow
// - bit 11 on violation count increment or overflow as selected
// - bit 10 when physical-layer-invalid becomes asserted
// - bit 9 on elastic buffer overflow or underflow
// - bit 8 noise timer zero, bit 7 connection timer zero
// - bit 6 once joined, scrubbed and active
// - bit 5 on entering break state
// - bit 4 on quiet or halt received in trace state
// - bit 3 on master received in active or trace state
// - bit 2 on receive flag rise after signalling done, or test end
// - bit 1 when line state equals programmed compare value
// - bit 0 on parity error at ten-bit transmit data input
// - mask at index 02, read/write, reset clear, never gates setting
module pei_event_irq #(
    parameter ADDR_W = 7,
    parameter ODD_PARITY = 1
) (
    input  wire              clock,
    input  wire              srst,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              ext_access_fault,
    input  wire              signal_detect_in,
    input  wire [7:0]        link_error_counter,
    input  wire              idle_min_drop,
    input  wire              idle_gap_inc,
    input  wire              idle_gap_ovf,
    input  wire              violation_inc,
    input  wire              violation_ovf,
    input  wire              phy_invalid,
    input  wire              ebuf_overflow,
    input  wire              ebuf_underflow,
    input  wire              noise_timer_zero,
    input  wire              connect_timer_zero,
    input  wire              join_output,
    input  wire              scrub_done,
    input  wire              pcm_active,
    input  wire              pcm_break,
    input  wire              pcm_trace,
    input  wire [2:0]        line_state,
    input  wire              signalling_done,
    input  wire              receive_complete_flag,
    input  wire              lct_done,
    input  wire [9:0]        tx_data,
    input  wire              tx_parity,
    input  wire              tx_valid,
    input  wire              self_test_done,
    output reg               self_test_run,
    output reg               idle_gap_event_select,
    output reg               violation_event_select,
    output reg  [2:0]        line_state_compare,
    output reg               int_n
);

    // ==============================================================
    // register index decode
    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_MASK = 3'h1;
    localparam [2:0] SEL_THR  = 3'h2;
    localparam [2:0] SEL_EV   = 3'h3;
    localparam [2:0] SEL_CTL  = 3'h4;

    function [2:0] reg_sel;
        input [ADDR_W-1:0] addr;
        begin
            case (addr[6:2])
                `PEI_IDX_MASK:      reg_sel = SEL_MASK;
                `PEI_IDX_THRESHOLD: reg_sel = SEL_THR;
                `PEI_IDX_EVENT:     reg_sel = SEL_EV;
                `PEI_IDX_CONTROL:   reg_sel = SEL_CTL;
                default:            reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    // ==============================================================
    // state
    reg [15:0]       event_report;
    reg [15:0]       event_enable_mask;
    reg [7:0]        link_error_threshold;
    reg [ADDR_W-1:0] wr_addr;
    reg [31:0]       wr_data;
    reg [3:0]        wr_strb;
    reg              aw_held;
    reg              w_held;
    reg              self_test_latch;
    reg              sd_prev;
    reg              inv_prev;
    reg              en_prev;
    reg              brk_prev;
    reg              tqh_prev;
    reg              tfwd_prev;
    reg              hit_prev;
    reg              rcf_prev;
    reg              code_pending;
    reg [7:0]        lec_prev;

    wire       wr_go    = aw_held & w_held & ~s_axi_bvalid;
    wire [2:0] wr_sel   = reg_sel(wr_addr);
    wire       rd_go    = s_axi_arvalid & s_axi_arready;
    wire [2:0] rd_sel   = reg_sel(s_axi_araddr);
    wire       rd_clear = rd_go & (rd_sel == SEL_EV);

    // ==============================================================
    // event conditions
    wire en_cond   = join_output & scrub_done & pcm_active;
    wire qh_seen   = (line_state == `PEI_LS_QUIET) |
                     (line_state == `PEI_LS_HALT);
    wire tqh_cond  = qh_seen & pcm_trace;
    wire tfwd_cond = (line_state == `PEI_LS_MASTER) &
                     (pcm_active | pcm_trace);
    wire hit_cond  = (line_state == line_state_compare);
    wire rcf_rise  = receive_complete_flag & ~rcf_prev;
    wire par_bad   = tx_valid &
                     ((^{tx_data, tx_parity}) != (ODD_PARITY != 0));
    // write to a read-only or unmapped register is a host fault
    wire bad_write = wr_go & ((wr_sel == SEL_EV) | (wr_sel == SEL_NONE));
    wire bad_read  = rd_go & (rd_sel == SEL_NONE);

    reg [15:0] ev_set;
    always @* begin
        ev_set = 16'h0000;
        ev_set[`PEI_EV_ACCESS_FAULT] = bad_write | bad_read |
                                       ext_access_fault;
        ev_set[`PEI_EV_SIG_DETECT] = signal_detect_in & ~sd_prev;
        ev_set[`PEI_EV_LINK_ERROR] = (link_error_counter == link_error_threshold)
                                     & (link_error_counter != lec_prev);
        ev_set[`PEI_EV_IDLE_GAP] = idle_min_drop |
            (idle_gap_event_select ? idle_gap_ovf : idle_gap_inc);
        ev_set[`PEI_EV_VIOLATION] =
            violation_event_select ? violation_ovf : violation_inc;
        ev_set[`PEI_EV_PHY_INVALID] = phy_invalid & ~inv_prev;
        ev_set[`PEI_EV_EBUF_FAULT] = ebuf_overflow | ebuf_underflow;
        ev_set[`PEI_EV_NOISE_ZERO] = noise_timer_zero;
        ev_set[`PEI_EV_CONNECT_ZERO] = connect_timer_zero;
        ev_set[`PEI_EV_ENABLED] = en_cond & ~en_prev;
        ev_set[`PEI_EV_BREAK] = pcm_break & ~brk_prev;
        ev_set[`PEI_EV_TRACE_QH] = tqh_cond & ~tqh_prev;
        ev_set[`PEI_EV_TRACE_FWD] = tfwd_cond & ~tfwd_prev;
        ev_set[`PEI_EV_CODE] = lct_done |
            ((code_pending | signalling_done) & rcf_rise);
        ev_set[`PEI_EV_LS_HIT] = hit_cond & ~hit_prev;
        ev_set[`PEI_EV_PARITY] = par_bad;
    end

    // ==============================================================
    // edge history and signalling-done hold
    always @(posedge clock) begin
        if (srst) begin
            sd_prev      <= 1'b0;
            inv_prev     <= 1'b0;
            en_prev      <= 1'b0;
            brk_prev     <= 1'b0;
            tqh_prev     <= 1'b0;
            tfwd_prev    <= 1'b0;
            hit_prev     <= 1'b0;
            rcf_prev     <= 1'b0;
            lec_prev     <= 8'h00;
            code_pending <= 1'b0;
        end else begin
            sd_prev   <= signal_detect_in;
            inv_prev  <= phy_invalid;
            en_prev   <= en_cond;
            brk_prev  <= pcm_break;
            tqh_prev  <= tqh_cond;
            tfwd_prev <= tfwd_cond;
            hit_prev  <= hit_cond;
            rcf_prev  <= receive_complete_flag;
            lec_prev  <= link_error_counter;
            // signalling done waits for the receive flag to rise again
            if (rcf_rise) begin
                code_pending <= 1'b0;
            end else if (signalling_done) begin
                code_pending <= 1'b1;
            end
        end
    end

    // ==============================================================
    // event register: a set in the read cycle survives the clear
    always @(posedge clock) begin
        if (srst) begin
            event_report <= `PEI_RST_EVENT;
        end else if (rd_clear) begin
            event_report <= ev_set;
        end else begin
            event_report <= event_report | ev_set;
        end
    end

    // ==============================================================
    // write channel
    always @(posedge clock) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PEI_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wr_addr       <= {ADDR_W{1'b0}};
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                wr_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                if (wr_sel == SEL_NONE) begin
                    s_axi_bresp <= `PEI_RESP_DECERR;
                end else if (wr_sel == SEL_EV) begin
                    s_axi_bresp <= `PEI_RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `PEI_RESP_OKAY;
                end
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==============================================================
    // writable registers
    always @(posedge clock) begin
        if (srst) begin
            event_enable_mask      <= `PEI_RST_MASK;
            link_error_threshold   <= `PEI_RST_THRESHOLD;
            self_test_run          <= 1'b0;
            idle_gap_event_select  <= 1'b0;
            violation_event_select <= 1'b0;
            line_state_compare     <= 3'h0;
        end else if (wr_go) begin
            if (wr_sel == SEL_MASK) begin
                if (wr_strb[0]) begin
                    event_enable_mask[7:0] <= wr_data[7:0];
                end
                if (wr_strb[1]) begin
                    event_enable_mask[15:8] <= wr_data[15:8];
                end
            end
            // upper byte has no storage, writes there vanish
            if (wr_sel == SEL_THR && wr_strb[0]) begin
                link_error_threshold <= wr_data[7:0];
            end
            if (wr_sel == SEL_CTL && wr_strb[0]) begin
                self_test_run          <= wr_data[`PEI_CTL_SELF_TEST];
                idle_gap_event_select  <= wr_data[`PEI_CTL_IDLE_SEL];
                violation_event_select <= wr_data[`PEI_CTL_VIOL_SEL];
                line_state_compare <= wr_data[`PEI_CTL_LS_MSB:`PEI_CTL_LS_LSB];
            end
        end
    end

    // ==============================================================
    // read channel
    always @(posedge clock) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PEI_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `PEI_RESP_OKAY;
            case (rd_sel)
                SEL_MASK: s_axi_rdata <= {16'h0000, event_enable_mask};
                SEL_THR:  s_axi_rdata <= {24'h000000, link_error_threshold};
                SEL_EV:   s_axi_rdata <= {16'h0000, event_report};
                SEL_CTL:  s_axi_rdata <= {26'h0000000, line_state_compare,
                                          violation_event_select,
                                          idle_gap_event_select, self_test_run};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `PEI_RESP_DECERR;
                end
            endcase
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==============================================================
    // interrupt pin
    // completion has no event bit, so it is held here until run clears
    always @(posedge clock) begin
        if (srst) begin
            self_test_latch <= 1'b0;
        end else if (!self_test_run) begin
            self_test_latch <= 1'b0;
        end else if (self_test_done) begin
            self_test_latch <= 1'b1;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            int_n <= 1'b1;
        end else if (self_test_run) begin
            int_n <= ~self_test_latch;
        end else begin
            int_n <= ~(|(event_report & event_enable_mask));
        end
    end

endmodule
`default_nettype wire

// ---- testbench/pei_event_irq_props.sv ----
// pei_event_irq_props.sv: bus and interrupt checks on pei_event_irq.
// assumes the design's port names; bound at the foot of this file.
`default_nettype none
module pei_event_irq_props #(
    parameter ADDR_W = 7
) (
    input wire logic              clock,
    input wire logic              srst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              self_test_done,
    input wire logic              self_test_run,
    input wire logic              int_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // ==========================================================
    // handshakes
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ==========================================================
    // properties
    a_reset_int_off: assert property ($past(srst) |-> int_n)
        else $error("int_n low after reset");
    a_write_answer: assert property (
        s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer late or early");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_read_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_thresh_high_zero: assert property (
        s_rd_taken ##0 s_axi_araddr[ADDR_W-1:2] == 5'h05
        |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
        else $error("threshold high bits not zero");
    a_event_ro_err: assert property (
        s_wr_taken ##0 s_axi_awaddr[ADDR_W-1:2] == 5'h17 |=> ##1 s_axi_bresp == 2'h2)
        else $error("write to event register accepted");
    a_unmapped_err: assert property (
        s_rd_taken ##0 !(s_axi_araddr[ADDR_W-1:2] inside {5'h02, 5'h05, 5'h17, 5'h1F})
        |=> s_axi_rresp == 2'h3)
        else $error("unmapped read not refused");
    a_test_blocks: assert property (
        !self_test_done ##1 ($rose(self_test_run) && !self_test_done) |=> int_n)
        else $error("interrupt not blocked in self test");
    a_test_done_int: assert property (
        self_test_run && self_test_done ##1 self_test_run |=> !int_n)
        else $error("self test completion not signalled");
endmodule

bind pei_event_irq pei_event_irq_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// ---- testbench/pei_host_model.sv ----
// pei_host_model.sv: node processor side, AXI4-Lite master tasks.
// assumes one clock shared with the block; wstrb always full word.
`default_nettype none
module pei_host_model (
    input  wire logic        clock,
    output var  logic [6:0]  s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    output var  logic [6:0]  s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end
    // ==========================================================
    // one word write; address and data offered together
    task automatic wr(input logic [6:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // ==========================================================
    // one word read
    task automatic rd(input logic [6:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- testbench/pei_event_irq_tb_top.sv ----
// pei_event_irq_tb_top.sv: self-checking bench for pei_event_irq.
// assumes pei_host_model as bus master and the bound checker.
`include "pei_map.vh"
`default_nettype none
module pei_event_irq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] A_MASK = 7'h08, A_THR = 7'h14, A_EV = 7'h5C, A_CTL = 7'h7C;
    // pulse events per select setting, index order of pl
    localparam logic [15:0] EX0 [11] = '{16'h8000, 16'h1000, 16'h1000, 16'h0000,
        16'h0800, 16'h0000, 16'h0200, 16'h0200, 16'h0100, 16'h0080, 16'h0004};
    localparam logic [15:0] EX1 [11] = '{16'h8000, 16'h1000, 16'h0000, 16'h1000,
        16'h0000, 16'h0800, 16'h0200, 16'h0200, 16'h0100, 16'h0080, 16'h0004};
    logic clock = 1'b0, srst = 1'b1;
    logic [10:0] pl = 11'h000;
    logic [7:0] link_error_counter = 8'h00;
    logic [9:0] tx_data = 10'h000;
    logic [2:0] line_state = 3'h7;
    logic tx_parity = 1'b1, tx_valid = 1'b1, self_test_done = 1'b0;
    logic signal_detect_in = 1'b0, phy_invalid = 1'b0, pcm_break = 1'b0, pcm_trace = 1'b0;
    logic join_output = 1'b0, scrub_done = 1'b0, pcm_active = 1'b0;
    logic signalling_done = 1'b0, receive_complete_flag = 1'b0;
    wire [6:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0] s_axi_wstrb;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    wire s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire ext_access_fault, idle_min_drop, idle_gap_inc, idle_gap_ovf, violation_inc;
    wire violation_ovf, ebuf_overflow, ebuf_underflow, noise_timer_zero;
    wire connect_timer_zero, lct_done, self_test_run, int_n;
    wire idle_gap_event_select, violation_event_select;
    wire [2:0] line_state_compare;
    int fails = 0, n_checks = 0, cyc = 0;
    logic [31:0] d;
    logic [1:0] r;
    assign {lct_done, connect_timer_zero, noise_timer_zero, ebuf_underflow, ebuf_overflow,
        violation_ovf, violation_inc, idle_gap_ovf, idle_gap_inc, idle_min_drop,
        ext_access_fault} = pl;
    pei_event_irq DUT (.*);
    pei_host_model host (.*);
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            summarize;
        end
    end
    // ==========================================================
    // compare helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [31:0] e, input string nm);
        host.rd(a, d, r);
        chk(nm, e, d);
        chk("rresp", {30'h0, `PEI_RESP_OKAY}, {30'h0, r});
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        host.wr(a, v, r);
        chk("bresp", {30'h0, `PEI_RESP_OKAY}, {30'h0, r});
    endtask
    task automatic evc(input logic [15:0] e);
        repeat (2) @(posedge clock);
        rchk(A_EV, {16'h0000, e}, "event_report");
    endtask
    task automatic irq(input logic e);
        repeat (3) @(posedge clock);
        #1;
        chk("int_n", {31'h0, e}, {31'h0, int_n});
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rchk(A_MASK, 32'h0, "mask reset");
        rchk(A_THR, 32'h0, "threshold reset");
        rchk(A_EV, 32'h0, "event reset");
        wr(A_THR, 32'hFFFF_FF07);
        rchk(A_THR, 32'h0000_0007, "threshold");
        link_error_counter <= 8'h06;
        evc(16'h0000);
        link_error_counter <= 8'h07;
        evc(16'h2000);
        for (int s = 0; s < 2; s++) begin
            wr(A_CTL, 32'(8'h28 | s * 6));
            chk("control", {26'h0, line_state_compare, violation_event_select,
                idle_gap_event_select, self_test_run}, 32'(8'h28 | s * 6));
            for (int i = 0; i < 11; i++) begin
                pl <= 11'(1 << i);
                @(posedge clock);
                pl <= 11'h000;
                evc(s ? EX1[i] : EX0[i]);
            end
        end
        signal_detect_in <= 1'b1;
        evc(16'h4000);
        phy_invalid <= 1'b1;
        evc(16'h0400);
        pcm_break <= 1'b1;
        evc(16'h0020);
        join_output <= 1'b1;
        scrub_done <= 1'b1;
        evc(16'h0000);
        pcm_active <= 1'b1;
        evc(16'h0040);
        line_state <= `PEI_LS_MASTER;
        evc(16'h0008);
        pcm_active <= 1'b0;
        pcm_trace <= 1'b1;
        line_state <= `PEI_LS_HALT;
        evc(16'h0010);
        line_state <= 3'h5;
        evc(16'h0002);
        tx_parity <= 1'b0;
        @(posedge clock);
        tx_parity <= 1'b1;
        evc(16'h0001);
        // bad parity while the transmit word is not valid is no error
        tx_valid <= 1'b0;
        tx_parity <= 1'b0;
        @(posedge clock);
        tx_valid <= 1'b1;
        tx_parity <= 1'b1;
        evc(16'h0000);
        signalling_done <= 1'b1;
        @(posedge clock);
        signalling_done <= 1'b0;
        evc(16'h0000);
        receive_complete_flag <= 1'b1;
        evc(16'h0004);
        host.wr(A_EV, 32'hFFFF, r);
        chk("bresp read-only", {30'h0, `PEI_RESP_SLVERR}, {30'h0, r});
        evc(16'h8000);
        host.rd(7'h30, d, r);
        chk("rresp unmapped", {30'h0, `PEI_RESP_DECERR}, {30'h0, r});
        evc(16'h8000);
        wr(A_MASK, 32'h0000_0100);
        rchk(A_MASK, 32'h0000_0100, "mask");
        pl <= 11'h200;
        @(posedge clock);
        pl <= 11'h000;
        irq(1'b1);
        pl <= 11'h100;
        @(posedge clock);
        pl <= 11'h000;
        irq(1'b0);
        wr(A_CTL, 32'h29);
        irq(1'b1);
        self_test_done <= 1'b1;
        @(posedge clock);
        self_test_done <= 1'b0;
        irq(1'b0);
        // events drained, so only the held completion keeps the pin low
        evc(16'h0180);
        irq(1'b0);
        wr(A_CTL, 32'h28);
        irq(1'b1);
        summarize;
    end
endmodule
`default_nettype wire
